//--- common/sbp_pkg.sv
// Package for the static branch predictor: types, modes and sizes
package sbp_pkg;
   localparam int ADDR_W = 32;
   localparam int THT_ENTRIES = 16;
   localparam int THT_IDX_W = 4;
   localparam int THT_TAG_W = ADDR_W - THT_IDX_W - 2;
   localparam int RAS_DEPTH = 16;
   localparam int RAS_PTR_W = 4;
   localparam logic [ADDR_W-1:0] PC_RESET = 32'h0000_0000;
   localparam logic [ADDR_W-1:0] INSN_BYTES = 32'h0000_0004;

   typedef enum logic [2:0] {
      SBP_CFG_FULL = 3'b001,
      SBP_CFG_REDUCED = 3'b010,
      SBP_CFG_NONE = 3'b100
   } sbp_cfg_e;

   typedef enum logic [3:0] {
      SBP_BR_COND = 4'b0001,
      SBP_BR_UNCOND = 4'b0010,
      SBP_BR_INDIRECT = 4'b0100,
      SBP_BR_RETURN = 4'b1000
   } sbp_kind_e;

   typedef struct packed {
      logic valid;
      sbp_kind_e kind;
      logic is_call;
      logic [ADDR_W-1:0] pc;
      logic [ADDR_W-1:0] target;
   } sbp_req_s;

   typedef struct packed {
      logic valid;
      sbp_kind_e kind;
      logic is_call;
      logic taken;
      logic [ADDR_W-1:0] pc;
      logic [ADDR_W-1:0] target;
   } sbp_upd_s;

   typedef struct packed {
      logic valid;
      logic taken;
      logic from_history;
      logic from_static;
      logic [ADDR_W-1:0] target;
   } sbp_pred_s;
endpackage

//--- rtl/sbp_predictor.sv
// Static and dynamic branch direction predictor with return stack
//
// Operation
// - History miss uses fixed static algorithm
// - Full and reduced modes: unconditional on miss predicted taken
// - Indirect branches on miss predicted not taken
// - Full mode: backward conditional predicted taken
// - Full mode: forward conditional predicted not taken
// - Reduced mode: conditional on miss predicted not taken
// - Never-taken conditional gets no table entry
// - Table miss clears tht_hit and reports a static prediction
// - Mode with no static heuristic
// - Indirect hit predicts last executed target
// - One taken target per indirect entry
// - Sixteen-entry return stack for calls, returns
`timescale 1ns/1ps
`default_nettype none
module sbp_predictor (
   input wire logic mclk,
   input wire logic sys_rst,
   input wire sbp_pkg::sbp_cfg_e cfg,
   input wire sbp_pkg::sbp_req_s req,
   input wire sbp_pkg::sbp_upd_s upd,
   output var sbp_pkg::sbp_pred_s pred,
   output logic tht_hit
);
   localparam int AW = sbp_pkg::ADDR_W;
   localparam int IW = sbp_pkg::THT_IDX_W;
   localparam int TW = sbp_pkg::THT_TAG_W;

   ////////////////////////////////////////////////////////////////
   // Target history table storage
   logic [sbp_pkg::THT_ENTRIES-1:0] tht_valid_reg;
   logic [TW-1:0] tht_tag_reg [sbp_pkg::THT_ENTRIES];
   logic [AW-1:0] tht_target_reg [sbp_pkg::THT_ENTRIES];
   logic [1:0] tht_ctr_reg [sbp_pkg::THT_ENTRIES];

   // Return stack
   localparam int RAS_PTR_W_L = sbp_pkg::RAS_PTR_W;
   logic [AW-1:0] ras_reg [sbp_pkg::RAS_DEPTH];
   logic [RAS_PTR_W_L-1:0] ras_ptr_reg;
   logic [RAS_PTR_W_L:0] ras_cnt_reg;

   ////////////////////////////////////////////////////////////////
   // Lookup
   wire [IW-1:0] rd_idx = req.pc[IW+1:2];
   wire [TW-1:0] rd_tag = req.pc[AW-1:IW+2];
   wire lookup_hit = req.valid && tht_valid_reg[rd_idx] && (tht_tag_reg[rd_idx] == rd_tag);
   wire [AW-1:0] fall_through = req.pc + sbp_pkg::INSN_BYTES;
   wire is_backward = req.target < req.pc;
   wire dyn_taken = tht_ctr_reg[rd_idx][1];
   wire ras_empty = (ras_cnt_reg == '0);
   wire [RAS_PTR_W_L-1:0] ras_top = ras_ptr_reg - 4'h1;

   // Static direction on a miss
   logic stat_taken;
   always_comb begin
      stat_taken = 1'b0;
      unique case (req.kind)
         sbp_pkg::SBP_BR_UNCOND: stat_taken = (cfg != sbp_pkg::SBP_CFG_NONE);
         sbp_pkg::SBP_BR_INDIRECT: stat_taken = 1'b0;
         sbp_pkg::SBP_BR_RETURN: stat_taken = !ras_empty;
         sbp_pkg::SBP_BR_COND: stat_taken = (cfg == sbp_pkg::SBP_CFG_FULL) && is_backward;
         default: stat_taken = 1'b0;
      endcase
   end

   // Prediction selection
   logic p_taken;
   logic [AW-1:0] p_target;
   always_comb begin
      if (lookup_hit) begin
         p_taken = (req.kind == sbp_pkg::SBP_BR_COND) ? dyn_taken : 1'b1;
         p_target = tht_target_reg[rd_idx];
      end else begin
         p_taken = stat_taken;
         p_target = req.target;
      end
      if (req.kind == sbp_pkg::SBP_BR_RETURN && !ras_empty) begin
         p_taken = 1'b1;
         p_target = ras_reg[ras_top];
      end
      if (!p_taken) begin
         p_target = fall_through;
      end
   end

   always_ff @(posedge mclk or posedge sys_rst) begin
      if (sys_rst) begin
         pred <= '0;
         tht_hit <= 1'b0;
      end else begin
         pred.valid <= req.valid;
         pred.taken <= req.valid && p_taken;
         pred.from_history <= lookup_hit;
         pred.from_static <= req.valid && !lookup_hit;
         pred.target <= p_target;
         tht_hit <= lookup_hit;
      end
   end

   ////////////////////////////////////////////////////////////////
   // Table update
   wire [IW-1:0] wr_idx = upd.pc[IW+1:2];
   wire [TW-1:0] wr_tag = upd.pc[AW-1:IW+2];
   wire wr_match = tht_valid_reg[wr_idx] && (tht_tag_reg[wr_idx] == wr_tag);
   wire alloc = upd.valid && upd.taken && !wr_match;
   wire ctr_upd = upd.valid && wr_match;

   genvar gi;
   generate
      for (gi = 0; gi < sbp_pkg::THT_ENTRIES; gi++) begin : g_tht
         wire sel = (wr_idx == IW'(gi));
         always_ff @(posedge mclk or posedge sys_rst) begin
            if (sys_rst) begin
               tht_valid_reg[gi] <= 1'b0;
               tht_tag_reg[gi] <= '0;
               tht_target_reg[gi] <= sbp_pkg::PC_RESET;
               tht_ctr_reg[gi] <= 2'h0;
            end else if (sel && alloc) begin
               tht_valid_reg[gi] <= 1'b1;
               tht_tag_reg[gi] <= wr_tag;
               tht_target_reg[gi] <= upd.target;
               tht_ctr_reg[gi] <= 2'h2;
            end else if (sel && ctr_upd) begin
               if (upd.taken) begin
                  tht_target_reg[gi] <= upd.target;
                  tht_ctr_reg[gi] <= (tht_ctr_reg[gi] == 2'h3) ? 2'h3 : tht_ctr_reg[gi] + 2'h1;
               end else begin
                  tht_ctr_reg[gi] <= (tht_ctr_reg[gi] == 2'h0) ? 2'h0 : tht_ctr_reg[gi] - 2'h1;
               end
            end
         end
      end
   endgenerate

   ////////////////////////////////////////////////////////////////
   // Return stack: calls push, returns pop, overflow wraps
   wire do_push = upd.valid && upd.is_call;
   wire do_pop = upd.valid && (upd.kind == sbp_pkg::SBP_BR_RETURN) && !ras_empty;
   wire [AW-1:0] ret_addr = upd.pc + sbp_pkg::INSN_BYTES;

   always_ff @(posedge mclk or posedge sys_rst) begin
      if (sys_rst) begin
         ras_ptr_reg <= '0;
         ras_cnt_reg <= '0;
      end else if (do_push && !do_pop) begin
         ras_ptr_reg <= ras_ptr_reg + 4'h1;
         ras_cnt_reg <= (ras_cnt_reg == 5'(sbp_pkg::RAS_DEPTH)) ? ras_cnt_reg : ras_cnt_reg + 5'h1;
      end else if (do_pop && !do_push) begin
         ras_ptr_reg <= ras_top;
         ras_cnt_reg <= ras_cnt_reg - 5'h1;
      end
   end

   always_ff @(posedge mclk) begin
      if (do_push) begin
         ras_reg[do_pop ? ras_top : ras_ptr_reg] <= ret_addr;
      end
   end

   ////////////////////////////////////////////////////////////////
   // Checks
   a_hit_overrides: assert property (@(posedge mclk) disable iff (sys_rst)
      req.valid |=> (pred.from_history == tht_hit) && (pred.from_static != tht_hit))
      else $error("hit and static source disagree");
   a_miss_uncond: assert property (@(posedge mclk) disable iff (sys_rst)
      (req.valid && !lookup_hit && req.kind == sbp_pkg::SBP_BR_UNCOND && cfg != sbp_pkg::SBP_CFG_NONE)
      |=> pred.taken)
      else $error("unconditional miss not taken");
   a_uncond_target: assert property (@(posedge mclk) disable iff (sys_rst)
      (req.valid && !lookup_hit && req.kind == sbp_pkg::SBP_BR_UNCOND && cfg != sbp_pkg::SBP_CFG_NONE)
      |=> pred.target == $past(req.target))
      else $error("unconditional miss not to its target");
   a_miss_indirect: assert property (@(posedge mclk) disable iff (sys_rst)
      (req.valid && !lookup_hit && req.kind == sbp_pkg::SBP_BR_INDIRECT)
      |=> !pred.taken && pred.target == $past(fall_through))
      else $error("indirect miss not fall-through");
   a_full_backward: assert property (@(posedge mclk) disable iff (sys_rst)
      (req.valid && !lookup_hit && req.kind == sbp_pkg::SBP_BR_COND && cfg == sbp_pkg::SBP_CFG_FULL
      && req.target < req.pc) |=> pred.taken)
      else $error("backward conditional not taken");
   a_full_forward: assert property (@(posedge mclk) disable iff (sys_rst)
      (req.valid && !lookup_hit && req.kind == sbp_pkg::SBP_BR_COND && req.target >= req.pc)
      |=> !pred.taken)
      else $error("forward conditional taken");
   a_reduced_cond: assert property (@(posedge mclk) disable iff (sys_rst)
      (req.valid && !lookup_hit && req.kind == sbp_pkg::SBP_BR_COND && cfg != sbp_pkg::SBP_CFG_FULL)
      |=> !pred.taken)
      else $error("conditional statically taken outside full mode");
   a_none_uncond: assert property (@(posedge mclk) disable iff (sys_rst)
      (req.valid && !lookup_hit && req.kind == sbp_pkg::SBP_BR_UNCOND && cfg == sbp_pkg::SBP_CFG_NONE)
      |=> !pred.taken)
      else $error("heuristic applied in mode none");
   a_no_alloc_nt: assert property (@(posedge mclk) disable iff (sys_rst)
      (upd.valid && !upd.taken && !tht_valid_reg[wr_idx]) |=> !tht_valid_reg[$past(wr_idx)])
      else $error("entry allocated for not-taken branch");
   a_miss_report: assert property (@(posedge mclk) disable iff (sys_rst)
      (req.valid && !lookup_hit) |=> !tht_hit && pred.from_static)
      else $error("miss not reported");
   a_idle_quiet: assert property (@(posedge mclk) disable iff (sys_rst)
      !req.valid |=> !pred.valid && !pred.taken && !tht_hit)
      else $error("prediction without request");
   a_indirect_hit: assert property (@(posedge mclk) disable iff (sys_rst)
      (req.valid && lookup_hit && req.kind == sbp_pkg::SBP_BR_INDIRECT)
      |=> pred.taken && pred.target == $past(tht_target_reg[rd_idx]))
      else $error("indirect hit not to last target");
   a_one_target: assert property (@(posedge mclk) disable iff (sys_rst)
      (upd.valid && upd.taken)
      |=> tht_valid_reg[$past(wr_idx)] && tht_target_reg[$past(wr_idx)] == $past(upd.target))
      else $error("entry not holding latest taken target");
   a_ras_return: assert property (@(posedge mclk) disable iff (sys_rst)
      (req.valid && req.kind == sbp_pkg::SBP_BR_RETURN && !ras_empty)
      |=> pred.taken && pred.target == $past(ras_reg[ras_top]))
      else $error("return not predicted from stack");
   a_ras_push: assert property (@(posedge mclk) disable iff (sys_rst)
      (upd.valid && upd.is_call && upd.kind != sbp_pkg::SBP_BR_RETURN)
      |=> ras_reg[$past(ras_ptr_reg)] == $past(ret_addr))
      else $error("call did not push return address");
   a_ras_bound: assert property (@(posedge mclk) disable iff (sys_rst)
      ras_cnt_reg <= 5'(sbp_pkg::RAS_DEPTH))
      else $error("return stack count above depth");
endmodule // sbp_predictor
`default_nettype wire

//--- bench/sbp_fetch_model.sv
// Fetch and resolve model that faces the predictor
`timescale 1ns/1ps
`default_nettype none
module sbp_fetch_model (
   input wire logic mclk,
   output var sbp_pkg::sbp_req_s req,
   output var sbp_pkg::sbp_upd_s upd
);
   initial begin
      req = '0;
      upd = '0;
   end
   // One lookup held over its request edge, then stale fields scrambled
   task automatic lookup(input sbp_pkg::sbp_kind_e k, input logic [31:0] pc, input logic [31:0] tg);
      @(posedge mclk);
      #1;
      req = '{1'b1, k, 1'b0, pc, tg};
      @(posedge mclk);
      #1;
      req = '{1'b0, k, 1'b1, ~pc, ~tg};
   endtask
   // One resolved branch as a single-cycle pulse
   task automatic resolve(input sbp_pkg::sbp_kind_e k, input logic call, input logic tk, input logic [31:0] pc,
                          input logic [31:0] tg);
      @(posedge mclk);
      #1;
      upd = '{1'b1, k, call, tk, pc, tg};
      @(posedge mclk);
      #1;
      upd = '{1'b0, k, ~call, ~tk, ~pc, ~tg};
   endtask
endmodule // sbp_fetch_model
`default_nettype wire

//--- bench/tb_top.sv
// Self-checking bench for the branch predictor
`timescale 1ns/1ps
`default_nettype none
module tb_top;
   logic mclk = 1'b0;
   logic sys_rst = 1'b1;
   sbp_pkg::sbp_cfg_e cfg = sbp_pkg::SBP_CFG_FULL;
   sbp_pkg::sbp_req_s req;
   sbp_pkg::sbp_upd_s upd;
   sbp_pkg::sbp_pred_s pred;
   logic tht_hit;
   int n_mismatch = 0;
   int cmp_count = 0;
   int cyc = 0;
   always #2 mclk = ~mclk;
   sbp_fetch_model i_fetch (.mclk(mclk), .req(req), .upd(upd));
   sbp_predictor i_dut (.mclk(mclk), .sys_rst(sys_rst), .cfg(cfg), .req(req), .upd(upd), .pred(pred),
                        .tht_hit(tht_hit));
   task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
      cmp_count++;
      if (seen !== exp) begin
         n_mismatch++;
         $display("Error at %0t: seen %h expected %h", $time, seen, exp);
      end
   endtask
   // Lookup, then judge direction, hit flag and next fetch address
   task automatic look(input sbp_pkg::sbp_kind_e k, input logic [31:0] pc, input logic [31:0] tg, input logic tk,
                       input logic hit, input logic [31:0] nxt);
      i_fetch.lookup(k, pc, tg);
      chk({30'h0, pred.valid, pred.taken}, {30'h0, 1'b1, tk});
      chk({31'h0, tht_hit}, {31'h0, hit});
      chk({30'h0, pred.from_history, pred.from_static}, {30'h0, hit, !hit});
      chk(pred.target, nxt);
   endtask
   task automatic t_static();
      cfg = sbp_pkg::SBP_CFG_FULL;
      look(sbp_pkg::SBP_BR_COND, 32'h100, 32'h80, 1'b1, 1'b0, 32'h80);
      look(sbp_pkg::SBP_BR_COND, 32'h100, 32'h180, 1'b0, 1'b0, 32'h104);
      look(sbp_pkg::SBP_BR_COND, 32'h100, 32'h100, 1'b0, 1'b0, 32'h104);
      look(sbp_pkg::SBP_BR_UNCOND, 32'h100, 32'h180, 1'b1, 1'b0, 32'h180);
      look(sbp_pkg::SBP_BR_INDIRECT, 32'h100, 32'h80, 1'b0, 1'b0, 32'h104);
   endtask
   task automatic t_modes();
      cfg = sbp_pkg::SBP_CFG_REDUCED;
      look(sbp_pkg::SBP_BR_COND, 32'h100, 32'h80, 1'b0, 1'b0, 32'h104);
      look(sbp_pkg::SBP_BR_UNCOND, 32'h100, 32'h80, 1'b1, 1'b0, 32'h80);
      cfg = sbp_pkg::SBP_CFG_NONE;
      look(sbp_pkg::SBP_BR_COND, 32'h100, 32'h80, 1'b0, 1'b0, 32'h104);
      look(sbp_pkg::SBP_BR_UNCOND, 32'h100, 32'h80, 1'b0, 1'b0, 32'h104);
   endtask
   task automatic t_history();
      cfg = sbp_pkg::SBP_CFG_FULL;
      i_fetch.resolve(sbp_pkg::SBP_BR_COND, 1'b0, 1'b0, 32'h300, 32'h200);
      look(sbp_pkg::SBP_BR_COND, 32'h300, 32'h200, 1'b1, 1'b0, 32'h200);
      i_fetch.resolve(sbp_pkg::SBP_BR_COND, 1'b0, 1'b1, 32'h140, 32'h1c0);
      look(sbp_pkg::SBP_BR_COND, 32'h140, 32'h1c0, 1'b1, 1'b1, 32'h1c0);
      i_fetch.resolve(sbp_pkg::SBP_BR_INDIRECT, 1'b0, 1'b1, 32'h404, 32'h800);
      look(sbp_pkg::SBP_BR_INDIRECT, 32'h404, 32'h0, 1'b1, 1'b1, 32'h800);
      i_fetch.resolve(sbp_pkg::SBP_BR_INDIRECT, 1'b0, 1'b1, 32'h404, 32'h900);
      look(sbp_pkg::SBP_BR_INDIRECT, 32'h404, 32'h0, 1'b1, 1'b1, 32'h900);
   endtask
   task automatic t_return();
      i_fetch.resolve(sbp_pkg::SBP_BR_UNCOND, 1'b1, 1'b1, 32'h200, 32'h1000);
      look(sbp_pkg::SBP_BR_RETURN, 32'h1000, 32'h0, 1'b1, 1'b0, 32'h204);
      i_fetch.resolve(sbp_pkg::SBP_BR_UNCOND, 1'b1, 1'b1, 32'h300, 32'h2000);
      look(sbp_pkg::SBP_BR_RETURN, 32'h2000, 32'h0, 1'b1, 1'b0, 32'h304);
      i_fetch.resolve(sbp_pkg::SBP_BR_RETURN, 1'b0, 1'b1, 32'h2000, 32'h304);
      look(sbp_pkg::SBP_BR_RETURN, 32'h2000, 32'h0, 1'b1, 1'b1, 32'h204);
   endtask
   task automatic summarize();
      if (n_mismatch == 0 && cmp_count > 0) begin
         $display("Test passed");
      end else begin
         $display("Test failed");
      end
      $finish;
   endtask
   initial begin
      repeat (10) @(posedge mclk);
      #1;
      sys_rst = 1'b0;
      t_static();
      t_modes();
      t_history();
      t_return();
      summarize();
   end
   always @(posedge mclk) begin
      cyc++;
      if (cyc == 2000) begin
         n_mismatch++;
         summarize();
      end
   end
endmodule // tb_top
`default_nettype wire
